// ==== hdl/sso_failsafe.sv ====
`timescale 1ns/1ps
// Fail-safe entry after persistent error, exit after self-recovery
module sso_failsafe
    import sso_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Timing in cycles
    input wire logic [15:0] persist_cycles,
    input wire logic [15:0] recover_cycles,
    // Diagnostic
    input wire logic diag_err,
    // State
    output logic failsafe,
    output logic self_reset
);
    typedef struct packed {
        sso_fs_e state_r;
        logic [15:0] cnt_r;
        logic reset_r;
    } sso_fs_s;

    sso_fs_s st_r;
    sso_fs_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.reset_r = 1'b0;
        case (st_r.state_r)
            SSO_FS_NORMAL: begin
                // Any break in the error restarts the persistence count
                if (!diag_err) begin
                    st_nxt.cnt_r = '0;
                end else if (st_r.cnt_r + 16'h0001 >= persist_cycles) begin
                    st_nxt.state_r = SSO_FS_HOLD;
                    st_nxt.cnt_r = '0;
                end else begin
                    st_nxt.cnt_r = st_r.cnt_r + 16'h0001;
                end
            end
            SSO_FS_HOLD: begin
                if (!diag_err) begin
                    st_nxt.state_r = SSO_FS_RECOVER;
                    st_nxt.cnt_r = '0;
                end
            end
            SSO_FS_RECOVER: begin
                if (diag_err) begin
                    st_nxt.state_r = SSO_FS_HOLD;
                end else if (st_r.cnt_r + 16'h0001 >= recover_cycles) begin
                    st_nxt.state_r = SSO_FS_NORMAL;
                    st_nxt.reset_r = 1'b1;
                    st_nxt.cnt_r = '0;
                end else begin
                    st_nxt.cnt_r = st_r.cnt_r + 16'h0001;
                end
            end
            default: begin
                st_nxt.state_r = SSO_FS_NORMAL;
                st_nxt.cnt_r = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '{state_r: SSO_FS_NORMAL, cnt_r: 16'h0000, reset_r: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign failsafe = st_r.state_r != SSO_FS_NORMAL;
    assign self_reset = st_r.reset_r;
endmodule

// ==== hdl/sso_params.svh ====
`ifndef SSO_PARAMS_SVH
`define SSO_PARAMS_SVH

// Register byte offsets
`define SSO_CFG_A_OFS 12'h000
`define SSO_CFG_B_OFS 12'h004
`define SSO_STAT_OFS 12'h008
`define SSO_CLR_OFS 12'h00C
`define SSO_FS_CFG_OFS 12'h010

// Switch configuration fields
`define SSO_SEL_LSB 0
`define SSO_SENSE_BIT 3
`define SSO_THR_LSB 16

// Reset values
`define SSO_CFG_RST 32'h0000_0000
`define SSO_FS_PERSIST_RST 16'h0064
`define SSO_FS_RECOVER_RST 16'h0064

// Status fields
`define SSO_ST_OUT_A 0
`define SSO_ST_OUT_B 1
`define SSO_ST_FAILSAFE 2
`define SSO_ST_RESET_LATCH 3

// Clear register bit
`define SSO_CLR_RESET_BIT 0

`endif

// ==== hdl/sso_pkg.sv ====
package sso_pkg;
    typedef enum logic [2:0] {
        SSO_SEL_UNUSED = 3'h0,
        SSO_SEL_FAILSAFE = 3'h1,
        SSO_SEL_RESET = 3'h2,
        SSO_SEL_POS_ERR = 3'h3,
        SSO_SEL_TIGHT = 3'h4,
        SSO_SEL_LOW = 3'h5,
        SSO_SEL_HIGH = 3'h6,
        SSO_SEL_MODE = 3'h7
    } sso_sel_e;

    typedef enum logic [2:0] {
        SSO_FS_NORMAL = 3'b001,
        SSO_FS_HOLD = 3'b010,
        SSO_FS_RECOVER = 3'b100
    } sso_fs_e;

    typedef logic [15:0] sso_pos_t;
endpackage

// ==== hdl/sso_switch.sv ====
`timescale 1ns/1ps
// One contact output: condition select, sense, registered drive
module sso_switch
    import sso_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Configuration
    input wire logic [2:0] sel,
    input wire logic sense,
    input wire sso_pkg::sso_pos_t thr,
    // Conditions
    input wire logic failsafe,
    input wire logic reset_latched,
    input wire logic pos_err,
    input wire logic tight_on,
    input wire sso_pkg::sso_pos_t tight_thr,
    input wire sso_pkg::sso_pos_t position,
    input wire logic abnormal_mode,
    // Contact drive, high closes
    output logic closed
);
    typedef struct packed {
        logic closed_r;
    } sso_sw_s;

    sso_sw_s st_r;
    sso_sw_s st_nxt;
    logic cond;

    always_comb begin
        case (sso_sel_e'(sel))
            SSO_SEL_UNUSED: cond = 1'b0;
            SSO_SEL_FAILSAFE: cond = failsafe;
            SSO_SEL_RESET: cond = reset_latched;
            SSO_SEL_POS_ERR: cond = pos_err;
            SSO_SEL_TIGHT: cond = tight_on && (position < tight_thr);
            SSO_SEL_LOW: cond = position < thr;
            SSO_SEL_HIGH: cond = position > thr;
            SSO_SEL_MODE: cond = abnormal_mode;
            default: cond = 1'b0;
        endcase
        st_nxt = st_r;
        // Unused switch stays open whatever the sense says
        if (sso_sel_e'(sel) == SSO_SEL_UNUSED) begin
            st_nxt.closed_r = 1'b0;
        end else begin
            st_nxt.closed_r = cond ^ sense;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign closed = st_r.closed_r;
endmodule

// ==== hdl/sso_top.sv ====
`timescale 1ns/1ps
`include "sso_params.svh"

module sso_top
    import sso_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [11:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Internal status from the control core
    input wire logic DIAG_ERR,
    input wire logic POS_ERR,
    input wire logic TIGHT_ON,
    input wire sso_pkg::sso_pos_t TIGHT_THR,
    input wire sso_pkg::sso_pos_t POSITION,
    input wire logic ABNORMAL_MODE,
    // Contacts and fail-safe command
    output logic CONTACT_OUTPUT_A,
    output logic CONTACT_OUTPUT_B,
    output logic FAILSAFE_DRIVE
);
    import sso_pkg::*;

    typedef struct packed {
        logic [31:0] cfg_a_r;
        logic [31:0] cfg_b_r;
        logic [31:0] fs_cfg_r;
        logic reset_latch_r;
        logic wr_pend_r;
        logic [11:0] wr_addr_r;
        logic [31:0] rdata_r;
    } sso_top_s;

    sso_top_s st_r;
    sso_top_s st_nxt;
    logic fs_active;
    logic fs_self_reset;
    logic addr_ph;

    function automatic logic [31:0] read_mux(input logic [11:0] a, input sso_top_s s,
                                             input logic fs, input logic oa,
                                             input logic ob);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `SSO_CFG_A_OFS: v = s.cfg_a_r;
            `SSO_CFG_B_OFS: v = s.cfg_b_r;
            `SSO_FS_CFG_OFS: v = s.fs_cfg_r;
            `SSO_STAT_OFS: begin
                v[`SSO_ST_OUT_A] = oa;
                v[`SSO_ST_OUT_B] = ob;
                v[`SSO_ST_FAILSAFE] = fs;
                v[`SSO_ST_RESET_LATCH] = s.reset_latch_r;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Bus slave: zero wait states, writes land one cycle after the address phase
    assign addr_ph = HSEL && HREADY && HTRANS[1];

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_pend_r = addr_ph && HWRITE;
        st_nxt.wr_addr_r = HADDR;
        if (addr_ph && !HWRITE) begin
            st_nxt.rdata_r = read_mux(HADDR, st_r, fs_active, CONTACT_OUTPUT_A,
                                      CONTACT_OUTPUT_B);
        end
        if (st_r.wr_pend_r) begin
            case (st_r.wr_addr_r)
                `SSO_CFG_A_OFS: st_nxt.cfg_a_r = HWDATA;
                `SSO_CFG_B_OFS: st_nxt.cfg_b_r = HWDATA;
                `SSO_FS_CFG_OFS: st_nxt.fs_cfg_r = HWDATA;
                default: st_nxt.cfg_a_r = st_r.cfg_a_r;
            endcase
        end
        // A self-reset sets the latch even in the cycle software clears it
        if (st_r.wr_pend_r && st_r.wr_addr_r == `SSO_CLR_OFS
            && HWDATA[`SSO_CLR_RESET_BIT]) begin
            st_nxt.reset_latch_r = 1'b0;
        end
        if (fs_self_reset) begin
            st_nxt.reset_latch_r = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_r.cfg_a_r <= `SSO_CFG_RST;
            st_r.cfg_b_r <= `SSO_CFG_RST;
            st_r.fs_cfg_r <= {`SSO_FS_RECOVER_RST, `SSO_FS_PERSIST_RST};
            st_r.reset_latch_r <= 1'b1;
            st_r.wr_pend_r <= 1'b0;
            st_r.wr_addr_r <= 12'h000;
            st_r.rdata_r <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign HRDATA = st_r.rdata_r;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Fail-safe supervisor
    sso_failsafe u_fs (
        .clk(SYS_CLK),
        .rst(RESET),
        .persist_cycles(st_r.fs_cfg_r[15:0]),
        .recover_cycles(st_r.fs_cfg_r[31:16]),
        .diag_err(DIAG_ERR),
        .failsafe(fs_active),
        .self_reset(fs_self_reset)
    );

    assign FAILSAFE_DRIVE = fs_active;

    ////////////////////////////////////////////////////////////////////////////////
    // Two identical switches; the external loop needs a DC series load
    sso_switch u_sw_a (
        .clk(SYS_CLK),
        .rst(RESET),
        .sel(st_r.cfg_a_r[`SSO_SEL_LSB +: 3]),
        .sense(st_r.cfg_a_r[`SSO_SENSE_BIT]),
        .thr(st_r.cfg_a_r[`SSO_THR_LSB +: 16]),
        .failsafe(fs_active),
        .reset_latched(st_r.reset_latch_r),
        .pos_err(POS_ERR),
        .tight_on(TIGHT_ON),
        .tight_thr(TIGHT_THR),
        .position(POSITION),
        .abnormal_mode(ABNORMAL_MODE),
        .closed(CONTACT_OUTPUT_A)
    );

    sso_switch u_sw_b (
        .clk(SYS_CLK),
        .rst(RESET),
        .sel(st_r.cfg_b_r[`SSO_SEL_LSB +: 3]),
        .sense(st_r.cfg_b_r[`SSO_SENSE_BIT]),
        .thr(st_r.cfg_b_r[`SSO_THR_LSB +: 16]),
        .failsafe(fs_active),
        .reset_latched(st_r.reset_latch_r),
        .pos_err(POS_ERR),
        .tight_on(TIGHT_ON),
        .tight_thr(TIGHT_THR),
        .position(POSITION),
        .abnormal_mode(ABNORMAL_MODE),
        .closed(CONTACT_OUTPUT_B)
    );
endmodule

// ==== testbench/sso_chk_properties.sv ====
`timescale 1ns/1ps
module sso_chk (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Bus
    input wire logic HSEL,
    input wire logic HREADY,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    // Status
    input wire logic DIAG_ERR,
    input wire logic CONTACT_OUTPUT_A,
    input wire logic CONTACT_OUTPUT_B,
    input wire logic FAILSAFE_DRIVE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // Run lengths of the error level; saturate so a long run never wraps
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    always_ff @(posedge SYS_CLK) begin
        hi_r <= (RESET || !DIAG_ERR) ? 8'h00 : hi_r + {7'h00, hi_r != 8'hFF};
        lo_r <= (RESET || DIAG_ERR) ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
    end
    sequence s_no_rd;
        !(HSEL && HREADY && HTRANS[1] && !HWRITE);
    endsequence
    AST_READY_ALWAYS: assert property (HREADYOUT)
        else $error("bus wait state inserted");
    AST_RESP_OKAY: assert property (!HRESP)
        else $error("bus error response");
    AST_RST_OPEN: assert property ($fell(RESET) |-> !CONTACT_OUTPUT_A && !CONTACT_OUTPUT_B)
        else $error("contact closed after reset");
    AST_RST_NO_FS: assert property ($fell(RESET) |-> !FAILSAFE_DRIVE)
        else $error("fail-safe active after reset");
    AST_FS_ENTRY: assert property ($rose(FAILSAFE_DRIVE) |-> hi_r >= 8'h08)
        else $error("fail-safe entered without persistent error");
    AST_FS_HOLD: assert property (FAILSAFE_DRIVE && DIAG_ERR |=> FAILSAFE_DRIVE)
        else $error("fail-safe left while error present");
    AST_FS_EXIT: assert property ($fell(FAILSAFE_DRIVE) |-> lo_r >= 8'h08)
        else $error("fail-safe left too early");
    AST_RD_STABLE: assert property (s_no_rd |=> $stable(HRDATA))
        else $error("read data changed without a read");
endmodule

// ==== testbench/sso_load.sv ====
`timescale 1ns/1ps
// Two DC loads, each in series with its contact
module sso_load (
    // Contacts, high closes
    input wire logic [1:0] closed,
    // Load current flowing
    output logic [1:0] lit
);
    // Supply holds the plus terminal positive, so only a closed contact conducts
    assign lit = closed;
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "sso_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench import sso_pkg::*;;
    logic SYS_CLK = 1'b0, RESET = 1'b1, HSEL = 1'b0, HWRITE = 1'b0, DIAG_ERR = 1'b0;
    logic POS_ERR = 1'b0, TIGHT_ON = 1'b0, ABNORMAL_MODE = 1'b0;
    logic [11:0] HADDR = '0;
    logic [1:0] HTRANS = '0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = '0, HRDATA, rd;
    sso_pos_t TIGHT_THR = 16'h0080, POSITION = '0;
    logic HREADY, HREADYOUT, HRESP, CONTACT_OUTPUT_A, CONTACT_OUTPUT_B, FAILSAFE_DRIVE;
    logic [1:0] lit;
    int errors = 0, samples_checked = 0;
    sso_top i_sso_top(.SYS_CLK, .RESET, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA,
        .HREADY, .HRDATA, .HREADYOUT, .HRESP, .DIAG_ERR, .POS_ERR, .TIGHT_ON, .TIGHT_THR,
        .POSITION, .ABNORMAL_MODE, .CONTACT_OUTPUT_A, .CONTACT_OUTPUT_B, .FAILSAFE_DRIVE);
    sso_load i_load(.closed({CONTACT_OUTPUT_B, CONTACT_OUTPUT_A}), .lit(lit));
    assign HREADY = HREADYOUT;
    initial forever #5 SYS_CLK = ~SYS_CLK;
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    // Bounded wait so a stuck slave ends the run instead of hanging it
    task rdy;
        int n;
        for (n = 0; n < 20 && HREADYOUT !== 1'b1; n++) @(posedge SYS_CLK);
        if (n == 20) begin
            errors++;
            end_sim;
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HWRITE <= w;
        HADDR <= a;
        HTRANS <= 2'h2;
        @(posedge SYS_CLK);
        rdy;
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(posedge SYS_CLK);
        rdy;
        rd = HRDATA;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task s_reset;
        xfer(1'b0, `SSO_FS_CFG_OFS, '0);
        `CHK(rd, 32'h0064_0064)
        xfer(1'b1, 12'h020, 32'hFFFF_FFFF);
        xfer(1'b0, 12'h020, '0);
        `CHK(rd, 32'h0000_0000)
        xfer(1'b1, `SSO_CFG_A_OFS, 32'h0000_0002);
        xfer(1'b1, `SSO_CFG_B_OFS, 32'h0000_000A);
        tick(2);
        `CHK(lit, 2'b01)
        xfer(1'b1, `SSO_CLR_OFS, 32'h0000_0001);
        tick(2);
        `CHK(lit, 2'b10)
    endtask
    task s_sel;
        logic [2:0] sels [6] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
        logic on;
        logic [1:0] want;
        foreach (sels[i]) begin
            xfer(1'b1, `SSO_CFG_A_OFS, {16'h0100, 13'h0000, sels[i]});
            xfer(1'b1, `SSO_CFG_B_OFS, {16'h0100, 13'h0001, sels[i]});
            for (int k = 0; k < 2; k++) begin
                on = k[0];
                POS_ERR <= on;
                TIGHT_ON <= on;
                ABNORMAL_MODE <= on;
                case (sels[i])
                    3'h4: POSITION <= on ? 16'h0040 : 16'h0080;
                    3'h5: POSITION <= on ? 16'h00FF : 16'h0100;
                    default: POSITION <= on ? 16'h0101 : 16'h0100;
                endcase
                tick(2);
                // Switch A has sense 0 and closes on the condition, B has sense 1
                want = (sels[i] == 3'h0) ? 2'b00 : {!on, on};
                `CHK(lit, want)
            end
        end
    endtask
    task s_fs;
        xfer(1'b1, `SSO_FS_CFG_OFS, 32'h000C_000A);
        xfer(1'b1, `SSO_CFG_A_OFS, 32'h0000_0001);
        xfer(1'b1, `SSO_CFG_B_OFS, 32'h0000_0009);
        DIAG_ERR <= 1'b1;
        tick(8);
        DIAG_ERR <= 1'b0;
        `CHK(FAILSAFE_DRIVE, 1'b0)
        tick(1);
        DIAG_ERR <= 1'b1;
        tick(14);
        `CHK(lit, 2'b01)
        xfer(1'b0, `SSO_STAT_OFS, '0);
        `CHK(rd[3:2], 2'b01)
        DIAG_ERR <= 1'b0;
        tick(8);
        `CHK(FAILSAFE_DRIVE, 1'b1)
        tick(8);
        xfer(1'b0, `SSO_STAT_OFS, '0);
        `CHK(rd[3:0], 4'b1010)
    endtask
    task s_midrst;
        RESET <= 1'b1;
        tick(3);
        RESET <= 1'b0;
        xfer(1'b0, `SSO_CFG_A_OFS, '0);
        `CHK(rd, `SSO_CFG_RST)
        `CHK(lit, 2'b00)
        // A mid-run reset counts as a reset that occurred
        xfer(1'b0, `SSO_STAT_OFS, '0);
        `CHK(rd[3:0], 4'b1000)
    endtask
    initial begin
        tick(12);
        RESET <= 1'b0;
        s_reset;
        s_sel;
        s_fs;
        s_midrst;
        end_sim;
    end
endmodule
bind sso_top sso_chk i_chk(.SYS_CLK, .RESET, .HSEL, .HREADY, .HTRANS, .HWRITE, .HRDATA,
    .HREADYOUT, .HRESP, .DIAG_ERR, .CONTACT_OUTPUT_A, .CONTACT_OUTPUT_B, .FAILSAFE_DRIVE);
